// >>> src/edo_map.vh
// register map, field positions and cycle counts of the edo dram controller
`ifndef EDO_MAP_VH
`define EDO_MAP_VH
// ==========================================
// register addresses
`define CFG1_ADDR 32'hFFFFF4A4
`define CFG3_ADDR 32'hFFFFF4AC
`define CFG4_ADDR 32'h0FFFF4B0
`define CFG6_ADDR 32'h0FFFF4B8
`define STAT_ADDR 32'hFFFFF4C0
// ==========================================
// configuration register layout
`define CFG_RESET 16'h3FC1
`define CFG_WMASK 16'hBFDF
`define PAGE_ACCESS_ENABLE 15
`define ROW_PRECHARGE_WAIT_HI 13
`define ROW_PRECHARGE_WAIT_LO 12
`define ROW_HOLD_WAIT_HI 11
`define ROW_HOLD_WAIT_LO 10
`define DATA_ACCESS_WAIT_HI 9
`define DATA_ACCESS_WAIT_LO 8
`define COL_PRECHARGE_WAIT_HI 7
`define COL_PRECHARGE_WAIT_LO 6
`define ROW_STROBE_HOLD_SEL 4
`define PAGE_ADDR_SHIFT_HI 3
`define PAGE_ADDR_SHIFT_LO 2
`define MUX_WIDTH_HI 1
`define MUX_WIDTH_LO 0
// ==========================================
// status register layout
`define STAT_BUSY 0
`define STAT_ROW_OPEN 1
`define STAT_SELF 2
`define STAT_REF_PEND 3
`define STAT_STATE_LO 4
// ==========================================
// refresh cycle counts, loaded as count minus one, and the base multiplexed address width
`define REF_PRE_CNT 2'h2
`define REF_CAS_CNT 2'h0
`define REF_RAS_CNT 2'h1
`define MUX_BASE_WIDTH 5'h08
`endif

// >>> src/edo_addr_mux.v
// row and column address multiplexer for one dram access
`timescale 1ns/1ps
`default_nettype none
`include "edo_map.vh"
module edo_addr_mux (
  input wire [25:0] addr_i,
  input wire [1:0] width_i,
  input wire [1:0] shift_i,
  output wire [10:0] row_pins_o,
  output wire [10:0] col_pins_o,
  output wire [25:0] row_key_o
);
  // ==========================================
  // address split
  wire [4:0] width;
  wire [25:0] shifted;
  wire [25:0] mask;
  wire [25:0] col_full;
  wire [25:0] row_full;
  assign width = `MUX_BASE_WIDTH + {3'h0, width_i};
  assign shifted = addr_i >> shift_i;
  assign mask = ~(26'h3FFFFFF << width);
  assign col_full = shifted & mask;
  assign row_key_o = shifted >> width;
  assign row_full = row_key_o & mask;
  assign row_pins_o = row_full[10:0];
  assign col_pins_o = col_full[10:0];
endmodule // edo_addr_mux
`default_nettype wire

// >>> src/edo_dram_controller.v
// edo dram controller: four region configurations, access sequencer, cbr refresh
//
// Contract
// - drive four row strobes, one per region, plus separate lower and upper column strobes.
// - row strobe may stay asserted between accesses when region hold bit is set.
// - keep four independent dram configurations, one per dram block space.
// - four programmable waits of 0 to 3 cycles each; the row precharge wait here takes code 0 as 1 cycle.
// - perform cas-before-ras refresh, including the self-refresh variant.
// - width code 00..11 selects 8, 9, 10 or 11 multiplexed address bits.
// - at 11 bits row is cpu a12..a22, column a1..a11, on pins A1..A11.
// - regions 1, 3, 4 and 6 each own a configuration register.
// - configuration registers are 16 bits, accessed only as whole units.
// - dram accesses take all waits from the region configuration only.
// - row hold field bits 11..10 add 0 to 3 waits.
// - data access field bits 9..8 add 0 to 3 waits.
// - column precharge bits 7..6 add 0..3 waits, at least one on page writes.
`timescale 1ns/1ps
`default_nettype none
`include "edo_map.vh"
module edo_dram_controller (
  input wire CLK_I,
  input wire RST_I,
  input wire [31:0] REG_ADDR_I,
  input wire [15:0] REG_WDATA_I,
  input wire REG_WR_I,
  input wire REG_RD_I,
  output reg [15:0] REG_RDATA_O,
  input wire MEM_REQ_I,
  input wire [3:0] MEM_REGION_I,
  input wire [25:0] MEM_ADDR_I,
  input wire MEM_WE_I,
  input wire [1:0] MEM_BE_I,
  output wire MEM_READY_O,
  output reg MEM_ACK_O,
  input wire REFRESH_REQ_I,
  input wire SELF_REFRESH_I,
  output reg SELF_REFRESH_ACT_O,
  output reg [3:0] ROW_STROBE_N_O,
  output reg LOWER_COL_STROBE_N_O,
  output reg UPPER_COL_STROBE_N_O,
  output reg DRAM_WE_N_O,
  output reg [10:0] DRAM_ADDR_O
);
  // ==========================================
  // states
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_PRE = 4'h1;
  localparam [3:0] S_ROW = 4'h2;
  localparam [3:0] S_COL = 4'h3;
  localparam [3:0] S_CPRE = 4'h4;
  localparam [3:0] S_RCAS = 4'h5;
  localparam [3:0] S_RRAS = 4'h6;
  localparam [3:0] S_SELF = 4'h7;
  localparam [3:0] S_REND = 4'h8;

  // ==========================================
  // functions
  function [2:0] reg_decode;
    input [31:0] addr;
    begin
      if (addr == `CFG1_ADDR) begin
        reg_decode = 3'h4;
      end else if (addr == `CFG3_ADDR) begin
        reg_decode = 3'h5;
      end else if (addr == `CFG4_ADDR) begin
        reg_decode = 3'h6;
      end else if (addr == `CFG6_ADDR) begin
        reg_decode = 3'h7;
      end else begin
        reg_decode = 3'h0;
      end
    end
  endfunction

  function [1:0] region_index;
    input [3:0] sel;
    begin
      if (sel[0]) begin
        region_index = 2'h0;
      end else if (sel[1]) begin
        region_index = 2'h1;
      end else if (sel[2]) begin
        region_index = 2'h2;
      end else begin
        region_index = 2'h3;
      end
    end
  endfunction

  function [1:0] at_least_one;
    input [1:0] code;
    begin
      at_least_one = (code == 2'h0) ? 2'h1 : code;
    end
  endfunction

  // ==========================================
  // declarations
  reg [15:0] cfg [0:3];
  reg [3:0] state;
  reg [1:0] cnt;
  reg [1:0] cur;
  reg row_open;
  reg [1:0] open_reg;
  reg [25:0] open_row;
  reg [25:0] lat_addr;
  reg lat_we;
  reg [1:0] lat_be;
  reg ref_pend;
  reg ref_seq;
  wire [2:0] wr_dec;
  wire [2:0] rd_dec;
  wire [1:0] in_idx;
  wire [15:0] cfg_in;
  wire [15:0] cfg_cur;
  wire take;
  wire ref_take;
  wire page_hit;
  wire [1:0] rp_eff;
  wire [1:0] cp_in;
  wire [1:0] cp_eff;
  wire [1:0] rh_cur;
  wire [1:0] da_cur;
  wire [10:0] in_col_pins;
  wire [25:0] in_row_key;
  wire [10:0] lat_row_pins;
  wire [10:0] lat_col_pins;
  wire [25:0] lat_row_key;
  wire [15:0] status;

  // ==========================================
  // register port
  assign wr_dec = reg_decode(REG_ADDR_I);
  assign rd_dec = reg_decode(REG_ADDR_I);
  assign status = {8'h00, state, ref_pend, SELF_REFRESH_ACT_O, row_open,
                   (state != S_IDLE)};

  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cfg[0] <= `CFG_RESET;
      cfg[1] <= `CFG_RESET;
      cfg[2] <= `CFG_RESET;
      cfg[3] <= `CFG_RESET;
    end else if (REG_WR_I && wr_dec[2]) begin
      // bits 14 and 5 are kept at zero whatever is written
      cfg[wr_dec[1:0]] <= REG_WDATA_I & `CFG_WMASK;
    end
  end

  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      REG_RDATA_O <= 16'h0000;
    end else if (REG_RD_I && rd_dec[2]) begin
      REG_RDATA_O <= cfg[rd_dec[1:0]];
    end else if (REG_RD_I && (REG_ADDR_I == `STAT_ADDR)) begin
      REG_RDATA_O <= status;
    end else begin
      REG_RDATA_O <= 16'h0000;
    end
  end

  // ==========================================
  // request decode and wait selection
  assign in_idx = region_index(MEM_REGION_I);
  assign cfg_in = cfg[in_idx];
  assign cfg_cur = cfg[cur];
  assign MEM_READY_O = (state == S_IDLE) && !ref_pend && !MEM_ACK_O;
  assign take = MEM_REQ_I && MEM_READY_O && (MEM_REGION_I != 4'h0);
  assign ref_take = (state == S_IDLE) && ref_pend;
  // page hit: same region, same row, row still open, paging enabled
  assign page_hit = row_open && (open_reg == in_idx) && (open_row == in_row_key) &&
                    cfg_in[`PAGE_ACCESS_ENABLE];
  // waits come only from the region configuration
  assign rp_eff = at_least_one(cfg_in[`ROW_PRECHARGE_WAIT_HI:`ROW_PRECHARGE_WAIT_LO]);
  assign cp_in = cfg_in[`COL_PRECHARGE_WAIT_HI:`COL_PRECHARGE_WAIT_LO];
  assign cp_eff = MEM_WE_I ? at_least_one(cp_in) : cp_in;
  assign rh_cur = cfg_cur[`ROW_HOLD_WAIT_HI:`ROW_HOLD_WAIT_LO];
  assign da_cur = cfg_cur[`DATA_ACCESS_WAIT_HI:`DATA_ACCESS_WAIT_LO];

  edo_addr_mux u_in_mux (
    .addr_i(MEM_ADDR_I),
    .width_i(cfg_in[`MUX_WIDTH_HI:`MUX_WIDTH_LO]),
    .shift_i(cfg_in[`PAGE_ADDR_SHIFT_HI:`PAGE_ADDR_SHIFT_LO]),
    .row_pins_o(),
    .col_pins_o(in_col_pins),
    .row_key_o(in_row_key)
  );

  edo_addr_mux u_lat_mux (
    .addr_i(lat_addr),
    .width_i(cfg_cur[`MUX_WIDTH_HI:`MUX_WIDTH_LO]),
    .shift_i(cfg_cur[`PAGE_ADDR_SHIFT_HI:`PAGE_ADDR_SHIFT_LO]),
    .row_pins_o(lat_row_pins),
    .col_pins_o(lat_col_pins),
    .row_key_o(lat_row_key)
  );

  // ==========================================
  // access and refresh sequencer
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state <= S_IDLE;
      cnt <= 2'h0;
      cur <= 2'h0;
      row_open <= 1'b0;
      open_reg <= 2'h0;
      open_row <= 26'h0000000;
      lat_addr <= 26'h0000000;
      lat_we <= 1'b0;
      lat_be <= 2'h0;
      ref_pend <= 1'b0;
      ref_seq <= 1'b0;
      MEM_ACK_O <= 1'b0;
      SELF_REFRESH_ACT_O <= 1'b0;
      ROW_STROBE_N_O <= 4'hF;
      LOWER_COL_STROBE_N_O <= 1'b1;
      UPPER_COL_STROBE_N_O <= 1'b1;
      DRAM_WE_N_O <= 1'b1;
      DRAM_ADDR_O <= 11'h000;
    end else begin
      MEM_ACK_O <= 1'b0;
      // a new request wins over the clear of the pending flag
      ref_pend <= REFRESH_REQ_I | (ref_pend & ~ref_take);
      case (state)
        S_IDLE: begin
          if (ref_pend) begin
            ROW_STROBE_N_O <= 4'hF;
            row_open <= 1'b0;
            ref_seq <= 1'b1;
            cnt <= `REF_PRE_CNT;
            state <= S_PRE;
          end else if (take) begin
            cur <= in_idx;
            lat_addr <= MEM_ADDR_I;
            lat_we <= MEM_WE_I;
            lat_be <= MEM_BE_I;
            ref_seq <= 1'b0;
            if (page_hit && (cp_eff == 2'h0)) begin
              DRAM_ADDR_O <= in_col_pins;
              LOWER_COL_STROBE_N_O <= ~MEM_BE_I[0];
              UPPER_COL_STROBE_N_O <= ~MEM_BE_I[1];
              DRAM_WE_N_O <= ~MEM_WE_I;
              cnt <= cfg_in[`DATA_ACCESS_WAIT_HI:`DATA_ACCESS_WAIT_LO];
              state <= S_COL;
            end else if (page_hit) begin
              cnt <= cp_eff - 2'h1;
              state <= S_CPRE;
            end else begin
              ROW_STROBE_N_O <= 4'hF;
              row_open <= 1'b0;
              cnt <= rp_eff - 2'h1;
              state <= S_PRE;
            end
          end
        end
        S_PRE: begin
          if (cnt != 2'h0) begin
            cnt <= cnt - 2'h1;
          end else if (ref_seq) begin
            LOWER_COL_STROBE_N_O <= 1'b0;
            UPPER_COL_STROBE_N_O <= 1'b0;
            cnt <= `REF_CAS_CNT;
            state <= S_RCAS;
          end else begin
            ROW_STROBE_N_O[cur] <= 1'b0;
            DRAM_ADDR_O <= lat_row_pins;
            row_open <= 1'b1;
            open_reg <= cur;
            open_row <= lat_row_key;
            cnt <= rh_cur;
            state <= S_ROW;
          end
        end
        S_ROW: begin
          if (cnt != 2'h0) begin
            cnt <= cnt - 2'h1;
          end else begin
            DRAM_ADDR_O <= lat_col_pins;
            LOWER_COL_STROBE_N_O <= ~lat_be[0];
            UPPER_COL_STROBE_N_O <= ~lat_be[1];
            DRAM_WE_N_O <= ~lat_we;
            cnt <= da_cur;
            state <= S_COL;
          end
        end
        S_CPRE: begin
          if (cnt != 2'h0) begin
            cnt <= cnt - 2'h1;
          end else begin
            DRAM_ADDR_O <= lat_col_pins;
            LOWER_COL_STROBE_N_O <= ~lat_be[0];
            UPPER_COL_STROBE_N_O <= ~lat_be[1];
            DRAM_WE_N_O <= ~lat_we;
            cnt <= da_cur;
            state <= S_COL;
          end
        end
        S_COL: begin
          if (cnt != 2'h0) begin
            cnt <= cnt - 2'h1;
          end else begin
            MEM_ACK_O <= 1'b1;
            LOWER_COL_STROBE_N_O <= 1'b1;
            UPPER_COL_STROBE_N_O <= 1'b1;
            DRAM_WE_N_O <= 1'b1;
            if (!cfg_cur[`ROW_STROBE_HOLD_SEL]) begin
              ROW_STROBE_N_O <= 4'hF;
              row_open <= 1'b0;
            end
            state <= S_IDLE;
          end
        end
        S_RCAS: begin
          if (cnt != 2'h0) begin
            cnt <= cnt - 2'h1;
          end else begin
            ROW_STROBE_N_O <= 4'h0;
            cnt <= `REF_RAS_CNT;
            state <= S_RRAS;
          end
        end
        S_RRAS: begin
          if (cnt != 2'h0) begin
            cnt <= cnt - 2'h1;
          end else if (SELF_REFRESH_I) begin
            SELF_REFRESH_ACT_O <= 1'b1;
            state <= S_SELF;
          end else begin
            ROW_STROBE_N_O <= 4'hF;
            LOWER_COL_STROBE_N_O <= 1'b1;
            UPPER_COL_STROBE_N_O <= 1'b1;
            cnt <= `REF_PRE_CNT;
            state <= S_REND;
          end
        end
        S_SELF: begin
          if (!SELF_REFRESH_I) begin
            SELF_REFRESH_ACT_O <= 1'b0;
            ROW_STROBE_N_O <= 4'hF;
            LOWER_COL_STROBE_N_O <= 1'b1;
            UPPER_COL_STROBE_N_O <= 1'b1;
            cnt <= `REF_PRE_CNT;
            state <= S_REND;
          end
        end
        S_REND: begin
          if (cnt != 2'h0) begin
            cnt <= cnt - 2'h1;
          end else begin
            ref_seq <= 1'b0;
            state <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule // edo_dram_controller
`default_nettype wire

// >>> verif/edo_ctrl_sva.sv
// assertion checker for the edo dram controller ports
`timescale 1ns/1ps
`default_nettype none
`include "edo_map.vh"
module edo_ctrl_sva (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [31:0] REG_ADDR_I,
  input wire logic REG_RD_I,
  input wire logic [15:0] REG_RDATA_O,
  input wire logic MEM_REQ_I,
  input wire logic [3:0] MEM_REGION_I,
  input wire logic MEM_READY_O,
  input wire logic MEM_ACK_O,
  input wire logic SELF_REFRESH_I,
  input wire logic SELF_REFRESH_ACT_O,
  input wire logic [3:0] ROW_STROBE_N_O,
  input wire logic LOWER_COL_STROBE_N_O,
  input wire logic UPPER_COL_STROBE_N_O,
  input wire logic DRAM_WE_N_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  wire logic cas_dn = !LOWER_COL_STROBE_N_O && !UPPER_COL_STROBE_N_O;
  wire logic rows_dn = ROW_STROBE_N_O == 4'h0;
  // ==========================================
  // access sequencing
  sequence s_take;
    MEM_REQ_I && MEM_READY_O && MEM_REGION_I != 4'h0;
  endsequence
  sequence s_ack_end;
    MEM_ACK_O ##1 !MEM_ACK_O;
  endsequence
  a_ack_bound: assert property (s_take |-> ##[2:12] MEM_ACK_O)
    else $error("ack outside wait range");
  a_take_busy: assert property (s_take |=> !MEM_READY_O)
    else $error("ready after take");
  a_ack_pulse: assert property (MEM_ACK_O |-> !MEM_READY_O and s_ack_end)
    else $error("ack not one cycle");
  a_ack_release: assert property (MEM_ACK_O |-> !cas_dn && DRAM_WE_N_O)
    else $error("strobes held at ack");
  a_we_in_col: assert property (!DRAM_WE_N_O
    |-> !(LOWER_COL_STROBE_N_O && UPPER_COL_STROBE_N_O))
    else $error("write enable outside column");
  a_one_row: assert property (!rows_dn |-> $onehot0(~ROW_STROBE_N_O))
    else $error("two row strobes");
  // ==========================================
  // registers and refresh
  a_rdata_idle: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 16'h0000)
    else $error("read data outside slot");
  a_rsvd_zero: assert property ($past(REG_RD_I) && $past(REG_ADDR_I) != `STAT_ADDR
    |-> !REG_RDATA_O[14] && !REG_RDATA_O[5]) else $error("reserved bit set");
  a_cbr_order: assert property ($rose(rows_dn) |-> $past(cas_dn))
    else $error("rows before columns");
  a_self_rows: assert property (SELF_REFRESH_ACT_O |-> rows_dn)
    else $error("self refresh rows high");
  a_self_exit: assert property (SELF_REFRESH_ACT_O && !SELF_REFRESH_I
    |-> ##[1:2] !SELF_REFRESH_ACT_O) else $error("self refresh stuck");
endmodule // edo_ctrl_sva
bind edo_dram_controller edo_ctrl_sva u_sva (
  .CLK_I(CLK_I), .RST_I(RST_I), .REG_ADDR_I(REG_ADDR_I), .REG_RD_I(REG_RD_I),
  .REG_RDATA_O(REG_RDATA_O), .MEM_REQ_I(MEM_REQ_I), .MEM_REGION_I(MEM_REGION_I),
  .MEM_READY_O(MEM_READY_O), .MEM_ACK_O(MEM_ACK_O), .SELF_REFRESH_I(SELF_REFRESH_I),
  .SELF_REFRESH_ACT_O(SELF_REFRESH_ACT_O), .ROW_STROBE_N_O(ROW_STROBE_N_O),
  .LOWER_COL_STROBE_N_O(LOWER_COL_STROBE_N_O), .UPPER_COL_STROBE_N_O(UPPER_COL_STROBE_N_O),
  .DRAM_WE_N_O(DRAM_WE_N_O));
`default_nettype wire

// >>> verif/edo_dram_model.sv
// behavioural edo dram chip: latches row, column, lanes and counts cbr refreshes
`timescale 1ns/1ps
`default_nettype none
module edo_dram_model (
  input wire logic clk_i,
  input wire logic [3:0] row_n_i,
  input wire logic lo_n_i,
  input wire logic up_n_i,
  input wire logic we_n_i,
  input wire logic [10:0] addr_i,
  output logic [10:0] row_o,
  output logic [10:0] col_o,
  output logic [3:0] sel_o,
  output logic [1:0] lane_o,
  output logic wr_o,
  output logic [7:0] cbr_o
);
  logic [3:0] row_p = 4'hF;
  logic cas_p = 1'h1;
  wire logic cas_n = lo_n_i & up_n_i;
  initial cbr_o = 8'h00;
  always @(posedge clk_i) begin
    if (&row_p && !(&row_n_i)) begin
      if (!cas_n) begin
        cbr_o <= cbr_o + 8'h01;
      end else begin
        row_o <= addr_i;
        sel_o <= ~row_n_i;
      end
    end
    if (cas_p && !cas_n && !(&row_n_i)) begin
      col_o <= addr_i;
      lane_o <= {~up_n_i, ~lo_n_i};
      wr_o <= ~we_n_i;
    end
    row_p <= row_n_i;
    cas_p <= cas_n;
  end
endmodule // edo_dram_model
`default_nettype wire

// >>> verif/edo_dram_controller_tb.sv
// self-checking bench for the edo dram controller
`timescale 1ns/1ps
`default_nettype none
`include "edo_map.vh"
module edo_dram_controller_tb;
  localparam logic [25:0] A = 26'h2ABCDEF;
  logic CLK_I = 1'h0;
  logic RST_I, REG_WR_I, REG_RD_I, MEM_REQ_I, MEM_WE_I, REFRESH_REQ_I, SELF_REFRESH_I;
  logic [31:0] REG_ADDR_I;
  logic [15:0] REG_WDATA_I;
  logic [3:0] MEM_REGION_I;
  logic [25:0] MEM_ADDR_I, m;
  logic [1:0] MEM_BE_I;
  wire logic [15:0] REG_RDATA_O;
  wire logic MEM_READY_O, MEM_ACK_O, SELF_REFRESH_ACT_O, lo_n, up_n, we_n, wr;
  wire logic [3:0] row_n, sel;
  wire logic [10:0] dram_addr, row, col;
  wire logic [1:0] lane;
  wire logic [7:0] cbr;
  int err_count = 0, checked = 0, cyc = 0, n;
  logic [31:0] cfg_addr [4] = '{`CFG1_ADDR, `CFG3_ADDR, `CFG4_ADDR, `CFG6_ADDR};
  logic [15:0] v [4];
  always #4 CLK_I = ~CLK_I;
  edo_dram_controller u_dut (.CLK_I(CLK_I), .RST_I(RST_I), .REG_ADDR_I(REG_ADDR_I),
    .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
    .REG_RDATA_O(REG_RDATA_O), .MEM_REQ_I(MEM_REQ_I), .MEM_REGION_I(MEM_REGION_I),
    .MEM_ADDR_I(MEM_ADDR_I), .MEM_WE_I(MEM_WE_I), .MEM_BE_I(MEM_BE_I),
    .MEM_READY_O(MEM_READY_O), .MEM_ACK_O(MEM_ACK_O), .REFRESH_REQ_I(REFRESH_REQ_I),
    .SELF_REFRESH_I(SELF_REFRESH_I), .SELF_REFRESH_ACT_O(SELF_REFRESH_ACT_O),
    .ROW_STROBE_N_O(row_n), .LOWER_COL_STROBE_N_O(lo_n), .UPPER_COL_STROBE_N_O(up_n),
    .DRAM_WE_N_O(we_n), .DRAM_ADDR_O(dram_addr));
  edo_dram_model u_mem (.clk_i(CLK_I), .row_n_i(row_n), .lo_n_i(lo_n), .up_n_i(up_n),
    .we_n_i(we_n), .addr_i(dram_addr), .row_o(row), .col_o(col), .sel_o(sel),
    .lane_o(lane), .wr_o(wr), .cbr_o(cbr));
  // ==========================================
  // shared tasks
  function automatic logic [15:0] cfg(input logic [1:0] rp, rh, da, cp,
      input logic hold, pae, input logic [1:0] w);
    return {pae, 1'h0, rp, rh, da, cp, 1'h0, hold, 2'h1, w};
  endfunction
  task automatic chk(input string nm, input logic [25:0] s, input logic [25:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic hold_rst;
    repeat (6) @(posedge CLK_I);
    RST_I <= 1'h0;
    @(posedge CLK_I);
  endtask
  task automatic wr_reg(input logic [31:0] a, input logic [15:0] d);
    REG_ADDR_I <= a;
    REG_WDATA_I <= d;
    REG_WR_I <= 1'h1;
    @(posedge CLK_I);
    REG_WR_I <= 1'h0;
    @(posedge CLK_I);
  endtask
  task automatic rd_reg(input logic [31:0] a, input logic [15:0] e);
    REG_ADDR_I <= a;
    REG_RD_I <= 1'h1;
    @(posedge CLK_I);
    REG_RD_I <= 1'h0;
    @(negedge CLK_I);
    chk("rdata", 26'(REG_RDATA_O), 26'(e));
    @(posedge CLK_I);
  endtask
  task automatic mem(input logic [3:0] rg, input logic [25:0] a, input logic w,
      input logic [1:0] be);
    MEM_REGION_I <= rg;
    MEM_ADDR_I <= a;
    MEM_WE_I <= w;
    MEM_BE_I <= be;
    MEM_REQ_I <= 1'h1;
    n = 0;
    do @(negedge CLK_I); while (MEM_READY_O !== 1'h1);
    @(posedge CLK_I);
    do begin @(negedge CLK_I); n++; end while (MEM_ACK_O !== 1'h1 && n < 40);
    @(posedge CLK_I);
    MEM_REQ_I <= 1'h0;
    MEM_REGION_I <= 4'h0;
    @(posedge CLK_I);
  endtask
  always @(posedge CLK_I) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      test_done;
    end
  end
  // ==========================================
  // scenarios
  initial begin
    RST_I = 1'h1;
    {REG_WR_I, REG_RD_I, MEM_REQ_I, MEM_WE_I, REFRESH_REQ_I, SELF_REFRESH_I} = 6'h00;
    REG_ADDR_I = 32'h00000000;
    REG_WDATA_I = 16'h0000;
    MEM_REGION_I = 4'h0;
    MEM_ADDR_I = 26'h0000000;
    MEM_BE_I = 2'h3;
    hold_rst;
    for (int j = 0; j < 4; j++) rd_reg(cfg_addr[j], 16'h3FC1);
    rd_reg(32'hFFFFF4A8, 16'h0000);
    for (int j = 0; j < 4; j++) begin
      v[j] = cfg(2'(3 - j), 2'(j), 2'(j), 2'h0, 1'h0, 1'h0, 2'(j));
      wr_reg(cfg_addr[j], v[j]);
    end
    for (int j = 0; j < 4; j++) rd_reg(cfg_addr[j], v[j]);
    for (int j = 0; j < 4; j++) begin
      m = (26'h1 << (8 + j)) - 26'h1;
      mem(4'(1 << j), A, 1'h0, 2'h3);
      chk("miss", 26'(n), 26'(((3 - j) > 1 ? 3 - j : 1) + 3 + 2 * j));
      chk("row", 26'(row) & m, (A >> (9 + j)) & m);
      chk("col", 26'(col) & m, (A >> 1) & m);
      chk("sel", 26'(sel), 26'(1 << j));
    end
    RST_I <= 1'h1;
    hold_rst;
    wr_reg(`CFG1_ADDR, cfg(2'h1, 2'h0, 2'h0, 2'h0, 1'h1, 1'h1, 2'h1));
    mem(4'h1, A, 1'h0, 2'h3);
    chk("pmiss", 26'(n), 26'h4);
    @(negedge CLK_I);
    chk("hold", 26'(row_n[0]), 26'h0);
    @(posedge CLK_I);
    mem(4'h1, A + 26'h2, 1'h0, 2'h3);
    chk("hit", 26'(n), 26'h2);
    mem(4'h1, A + 26'h4, 1'h1, 2'h1);
    chk("hitwr", 26'(n), 26'h3);
    chk("lane", 26'({wr, lane}), 26'h5);
    mem(4'h1, A + 26'h400, 1'h0, 2'h3);
    chk("reopen", 26'(n), 26'h4);
    chk("rerow", 26'(row), ((A + 26'h400) >> 10) & 26'h1FF);
    SELF_REFRESH_I <= 1'h1;
    REFRESH_REQ_I <= 1'h1;
    @(posedge CLK_I);
    REFRESH_REQ_I <= 1'h0;
    n = 0;
    do begin @(negedge CLK_I); n++; end while (SELF_REFRESH_ACT_O !== 1'h1 && n < 40);
    chk("self", 26'(SELF_REFRESH_ACT_O), 26'h1);
    chk("cbr", 26'(cbr), 26'h1);
    @(posedge CLK_I);
    rd_reg(`STAT_ADDR, 16'h0075);
    SELF_REFRESH_I <= 1'h0;
    mem(4'h1, A + 26'h400, 1'h0, 2'h3);
    chk("remiss", 26'(n), 26'h4);
    test_done;
  end
endmodule // edo_dram_controller_tb
`default_nettype wire
